// [design/sram_arb_map.vh]
// constants for the shared sram arbiter
`ifndef SRAM_ARB_MAP_VH
`define SRAM_ARB_MAP_VH
`define ARB_DATA_W      32
`define ARB_ADDR_W      14
`define ARB_OWNER_CORE  1'b0
`define ARB_OWNER_AHB   1'b1
`define ARB_RESET_OWNER 1'b0
`endif

// [design/sram_dual_port_arbiter.v]
// arbiter sharing one 32-bit sram between the core data port and the ahb side
`timescale 1ns/1ps
`include "sram_arb_map.vh"

module sram_dual_port_arbiter #(
	parameter DATA_W = `ARB_DATA_W,
	parameter ADDR_W = `ARB_ADDR_W
) (
	input  wire              clk,          // 200 MHz system clock
	input  wire              nrst,         // async reset, active low
	input  wire              core_req,     // core data port request
	input  wire              core_we,      // core write
	input  wire [ADDR_W-1:0] core_addr,    // core word address
	input  wire [DATA_W-1:0] core_wdata,   // core write data
	input  wire [DATA_W/8-1:0] core_be,    // core byte enables
	output reg               core_ready,   // core access taken the previous cycle
	output reg               core_rvalid,  // core read data valid
	output reg  [DATA_W-1:0] core_rdata,   // core read data
	input  wire              ahb_req,      // ahb side request (cpu fetch or dma)
	input  wire              ahb_we,       // ahb write
	input  wire [ADDR_W-1:0] ahb_addr,     // ahb word address
	input  wire [DATA_W-1:0] ahb_wdata,    // ahb write data
	input  wire [DATA_W/8-1:0] ahb_be,     // ahb byte enables
	output reg               ahb_ready,    // ahb access taken the previous cycle
	output reg               ahb_rvalid,   // ahb read data valid
	output reg  [DATA_W-1:0] ahb_rdata,    // ahb read data
	output reg               grant_ahb     // current owner, 1 = ahb
);
	reg              owner;        // parked or active owner
	reg              next_owner;
	reg              take_core;
	reg              take_ahb;
	reg              rd_core;      // a core read is in flight
	reg              rd_ahb;       // an ahb read is in flight
	wire [DATA_W-1:0] mem_rdata;

	// choose who uses the sram this cycle; the owner wins a tie and then
	// hands over, so two steady requesters interleave word by word
	always @* begin
		take_core  = 1'b0;
		take_ahb   = 1'b0;
		next_owner = owner;
		if (core_req && ahb_req) begin
			if (owner == `ARB_OWNER_CORE) begin
				take_core  = 1'b1;
				next_owner = `ARB_OWNER_AHB;
			end else begin
				take_ahb   = 1'b1;
				next_owner = `ARB_OWNER_CORE;
			end
		end else if (core_req) begin
			take_core  = 1'b1;
			next_owner = `ARB_OWNER_CORE;
		end else if (ahb_req) begin
			take_ahb   = 1'b1;
			next_owner = `ARB_OWNER_AHB;
		end
		// with no request next_owner keeps owner: parked
	end

	// owner and handshake registers; reset parks on the core
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			owner       <= `ARB_RESET_OWNER;
			grant_ahb   <= `ARB_RESET_OWNER;
			core_ready  <= 1'b0;
			ahb_ready   <= 1'b0;
			rd_core     <= 1'b0;
			rd_ahb      <= 1'b0;
		end else begin
			owner       <= next_owner;
			grant_ahb   <= next_owner;
			core_ready  <= take_core;
			ahb_ready   <= take_ahb;
			rd_core     <= take_core & ~core_we;
			rd_ahb      <= take_ahb & ~ahb_we;
		end
	end

	// read data steered to whichever side issued the read
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			core_rvalid <= 1'b0;
			ahb_rvalid  <= 1'b0;
			core_rdata  <= {DATA_W{1'b0}};
			ahb_rdata   <= {DATA_W{1'b0}};
		end else begin
			core_rvalid <= rd_core;
			ahb_rvalid  <= rd_ahb;
			if (rd_core) begin
				core_rdata <= mem_rdata;
			end
			if (rd_ahb) begin
				ahb_rdata <= mem_rdata;
			end
		end
	end

	// one shared port; address mux follows the cycle's winner
	sram_word_store #(
		.DATA_W (DATA_W),
		.ADDR_W (ADDR_W)
	) u_store (
		.clk   (clk),
		.en    (take_core | take_ahb),
		.we    (take_core ? core_we : ahb_we),
		.addr  (take_core ? core_addr : ahb_addr),
		.wdata (take_core ? core_wdata : ahb_wdata),
		.be    (take_core ? core_be : ahb_be),
		.rdata (mem_rdata)
	);
endmodule // sram_dual_port_arbiter

// [design/sram_word_store.v]
// single-port word memory with registered read data
`timescale 1ns/1ps
module sram_word_store #(
	parameter DATA_W = 32,
	parameter ADDR_W = 14
) (
	input  wire              clk,   // system clock
	input  wire              en,    // access strobe
	input  wire              we,    // write when high
	input  wire [ADDR_W-1:0] addr,  // word address
	input  wire [DATA_W-1:0] wdata, // write data
	input  wire [DATA_W/8-1:0] be,  // byte enables
	output reg  [DATA_W-1:0] rdata  // registered read data
);
	reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	integer i;

	// byte-lane writes, read-before-write data out
	always @(posedge clk) begin
		if (en) begin
			if (we) begin
				for (i = 0; i < DATA_W/8; i = i + 1) begin
					if (be[i]) begin
						mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
					end
				end
			end
			rdata <= mem[addr];
		end
	end
endmodule // sram_word_store

// [test/arb_properties.sv]
// arbiter port checker
`timescale 1ns/1ps
module arb_chk (input clk, nrst, core_req, ahb_req, core_ready, ahb_ready, grant_ahb);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_tie; core_req && ahb_req |=> grant_ahb != $past(grant_ahb)
		&& core_ready == grant_ahb; endproperty
	a_tie: assert property (p_tie) else $error("tie");
	property p_one; core_req ^ ahb_req |=> grant_ahb == $past(ahb_req)
		&& ahb_ready == grant_ahb; endproperty
	a_one: assert property (p_one) else $error("lone");
	property p_park; !core_req && !ahb_req |=> $stable(grant_ahb); endproperty
	a_park: assert property (p_park) else $error("park");
	property p_excl; !(core_ready && ahb_ready); endproperty
	a_excl: assert property (p_excl) else $error("two ready");
	property p_core_took; core_ready |-> $past(core_req); endproperty
	a_core_took: assert property (p_core_took) else $error("core ready unasked");
	property p_ahb_took; ahb_ready |-> $past(ahb_req); endproperty
	a_ahb_took: assert property (p_ahb_took) else $error("ahb ready unasked");
endmodule // arb_chk
bind sram_dual_port_arbiter arb_chk chk_u (.*);

// [test/masters.sv]
// core data port and ahb requesters
`timescale 1ns/1ps
module masters (input clk, c_on, a_on, core_ready, ahb_ready, // traffic wanted, taken
	output reg core_req = 0, ahb_req = 0, output reg [13:0] core_addr = 0, ahb_addr = 0);
	// refused request held unchanged, so it wins the next cycle
	always @(posedge clk) #2 if (core_ready | !core_req) core_req <= c_on;
	always @(posedge clk) #2 if (ahb_ready | !ahb_req) ahb_req <= a_on;
	always @(posedge clk) #2 core_addr <= core_addr + core_ready; // next word
	always @(posedge clk) #2 ahb_addr <= ahb_addr + ahb_ready;
endmodule // masters

// [test/sram_dual_port_arbiter_test.sv]
// sram arbiter bench
`timescale 1ns/1ps
module sram_dual_port_arbiter_test;
	reg clk = 0, nrst = 0, c_on = 0, a_on = 0, c_we = 1;
	integer err_count = 0, checked = 0, nc, na, n;
	wire core_req, ahb_req, core_ready, ahb_ready, grant_ahb, core_rvalid, ahb_rvalid;
	wire [13:0] core_addr, ahb_addr;
	wire [31:0] ahb_rdata, core_rdata;
	always #2.5 clk = ~clk; // 5 ns period
	masters m_u (.clk(clk), .c_on(c_on), .a_on(a_on), .core_ready(core_ready),
		.ahb_ready(ahb_ready), .core_req(core_req), .ahb_req(ahb_req),
		.core_addr(core_addr), .ahb_addr(ahb_addr));
	// core address folded to four words so a later read finds written data
	sram_dual_port_arbiter dut_u (.clk(clk), .nrst(nrst), .core_req(core_req),
		.core_we(c_we), .core_addr(core_addr & 14'h3), .core_wdata({2{2'h1, core_addr}}),
		.core_be(4'hF), .core_ready(core_ready), .core_rvalid(core_rvalid),
		.core_rdata(core_rdata), .ahb_req(ahb_req), .ahb_we(1'b0), .ahb_addr(ahb_addr),
		.ahb_wdata(32'h0), .ahb_be(4'hF), .ahb_ready(ahb_ready), .ahb_rvalid(ahb_rvalid),
		.ahb_rdata(ahb_rdata), .grant_ahb(grant_ahb));
	task chk(input [40:0] got, exp);
		checked++;
		err_count += got !== exp;
		if (got !== exp) $display("BAD %0t got %h", $time, got);
	endtask
	task run(input c, a, input integer n);
		{c_on, a_on, nc, na} = {c, a, 64'h0};
		repeat (n) #5 {nc, na} = {nc + core_ready, na + ahb_ready};
		{c_on, a_on} = 0;
	endtask
	task s_core; // core writes
		run(1, 0, 4);
		chk({nc[3:0], grant_ahb}, {4'h4, 1'b0});
	endtask
	task s_ahb; // ahb reads, then idles
		run(0, 1, 3);
		#5 chk(ahb_rvalid, 1'b1);
		#15 chk({na[3:0], grant_ahb}, {4'h3, 1'b1});
		chk(ahb_rdata, {2{2'h1, 14'h2}});
	endtask
	task s_tie; // both from the ahb park
		run(1, 1, 8);
		chk({nc[3:0], na[3:0]}, 8'h44);
	endtask
	task s_rd; // core reads back word 0, last written with address 4
		c_we = 0;
		run(1, 0, 1);
		n = 0;
		while (!core_rvalid && n < 10) begin
			#5 n = n + 1;
		end
		chk({core_rvalid, core_rdata}, {1'b1, 2'h1, 14'h4, 2'h1, 14'h4});
	endtask
	task close_out;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		#1 nrst = 1;
		s_core;
		s_ahb;
		s_tie;
		s_rd;
		close_out;
	end
endmodule // sram_dual_port_arbiter_test
